/* design/chan_freq_defines.vh */
// constants for the channel frequency configuration register set
// assumes a single 20 MHz clock and a register port with one-cycle strobes

`ifndef CHAN_FREQ_DEFINES_VH
`define CHAN_FREQ_DEFINES_VH

// ==========================================================
// register numbers
`define REG_RESET_ENABLE 8'h32
`define REG_GRID_SPACING 8'h34
`define REG_FCF_THZ 8'h35
`define REG_FCF_FRAC 8'h36
`define REG_IRQ_STATUS 8'h38
`define REG_IRQ_MASK 8'h39
`define REG_ERR_COND 8'h3a
`define REG_NV_CTRL 8'h3b
`define REG_LASER_THZ 8'h40
`define REG_LASER_FRAC 8'h41

// ==========================================================
// field positions
`define ENA_BIT 3
`define NV_SAVE_BIT 0
`define NV_RESTORE_BIT 1
`define IRQ_REJECT_BIT 0
`define IRQ_TUNE_DONE_BIT 1
`define IRQ_TUNE_DROP_BIT 2
`define IRQ_W 3

// ==========================================================
// error condition codes
`define ERR_NONE 4'h0
`define ERR_NOT_WRITABLE 4'h1
`define ERR_BAD_REGISTER 4'h2
`define ERR_OUTPUT_ON 4'h3

// ==========================================================
// arithmetic
`define FREQ_W 42
`define CNT_W 6
`define MHZ_PER_DECI 42'h00000000064
`define MHZ_PER_THZ 42'h000000f4240
`define DECI_PER_THZ 42'h00000002710
`define WORD_MAX 42'h0000000ffff

`endif

/* design/freq_sum.v */
// sums the channel frequency terms in MHz, signed, registered on load
// assumes its inputs stand still on the load cycle; same clock as the caller
`timescale 1ns/1ns
`default_nettype none
`include "chan_freq_defines.vh"

module freq_sum (
   input wire mclk_i,
   input wire rst_n_i,
   input wire load_i,
   input wire [15:0] channel_i,
   input wire [15:0] grid_i,
   input wire [15:0] fcf_thz_i,
   input wire [15:0] fcf_frac_i,
   input wire [15:0] fine_tune_offset_i,
   output reg [`FREQ_W-1:0] sum_q,
   output reg neg_q
);
   // ==========================================================
   // terms, all widened before any product so nothing overflows
   wire signed [`FREQ_W-1:0] ch_m1;
   wire signed [`FREQ_W-1:0] grid_x;
   wire signed [`FREQ_W-1:0] step_mhz;
   wire signed [`FREQ_W-1:0] base_mhz;
   wire signed [`FREQ_W-1:0] ftf_x;
   wire signed [`FREQ_W-1:0] total;

   assign ch_m1 = $signed({{(`FREQ_W-16){1'b0}}, channel_i}) - $signed({{(`FREQ_W-1){1'b0}}, 1'b1});
   assign grid_x = {{(`FREQ_W-16){grid_i[15]}}, grid_i}; // spacing is signed
   assign step_mhz = ch_m1 * grid_x * $signed(`MHZ_PER_DECI);
   assign base_mhz = $signed({{(`FREQ_W-16){1'b0}}, fcf_thz_i}) * $signed(`MHZ_PER_THZ)
      + $signed({{(`FREQ_W-16){1'b0}}, fcf_frac_i}) * $signed(`MHZ_PER_DECI);
   assign ftf_x = {{(`FREQ_W-16){fine_tune_offset_i[15]}}, fine_tune_offset_i};
   assign total = step_mhz + base_mhz + ftf_x;

   // ==========================================================
   // capture; a negative total is flagged, the caller clamps it
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sum_q <= {`FREQ_W{1'b0}};
         neg_q <= 1'b0;
      end else if (load_i) begin
         sum_q <= total;
         neg_q <= total[`FREQ_W-1];
      end
   end
endmodule // freq_sum

`default_nettype wire

/* design/seq_div.v */
// restoring unsigned divider, one quotient bit per clock
// assumes divisor is nonzero and well under 2**(W-1); start ignored while busy
`timescale 1ns/1ns
`default_nettype none
`include "chan_freq_defines.vh"

module seq_div #(
   parameter W = `FREQ_W
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire [W-1:0] dividend_i,
   input wire [W-1:0] divisor_i,
   output reg busy_q,
   output reg done_q,
   output reg [W-1:0] quot_q,
   output reg [W-1:0] rem_q
);
   reg [W-1:0] div_q;
   reg [`CNT_W-1:0] cnt_q;
   wire [W-1:0] shifted;
   wire [W:0] trial;

   assign shifted = {rem_q[W-2:0], quot_q[W-1]};
   assign trial = {1'b0, shifted} - {1'b0, div_q};

   // ==========================================================
   // shift-subtract loop; slow but tiny, tuning is not time critical
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         quot_q <= {W{1'b0}};
         rem_q <= {W{1'b0}};
         div_q <= {W{1'b0}};
         cnt_q <= {`CNT_W{1'b0}};
      end else begin
         done_q <= 1'b0;
         if (!busy_q && start_i) begin
            quot_q <= dividend_i;
            rem_q <= {W{1'b0}};
            div_q <= divisor_i;
            cnt_q <= W[`CNT_W-1:0];
            busy_q <= 1'b1;
         end else if (busy_q) begin
            rem_q <= trial[W] ? shifted : trial[W-1:0];
            quot_q <= {quot_q[W-2:0], ~trial[W]};
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule // seq_div

`default_nettype wire

/* design/chan_freq_regs.v */
// channel frequency configuration registers with tuning computation
// assumes a same-clock register master and a same-clock tuning engine
// that pulses tune_req_i with channel and fine tune offset held stable
`timescale 1ns/1ns
`default_nettype none
`include "chan_freq_defines.vh"

module chan_freq_regs #(
   parameter [15:0] GRID_DEFAULT = 16'h01f4,
   parameter [15:0] FCF_THZ_DEFAULT = 16'h00c2,
   parameter [15:0] FCF_FRAC_DEFAULT = 16'h06d6
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   output reg resp_valid_o,
   output reg resp_xe_o,
   output reg [3:0] resp_cond_o,
   input wire tune_req_i,
   input wire [15:0] channel_i,
   input wire [15:0] fine_tune_offset_i,
   output reg tune_busy_o,
   output reg output_enable_o,
   output reg [15:0] grid_spacing_o,
   output reg [15:0] first_channel_freq_thz_o,
   output reg [15:0] first_channel_freq_frac_o,
   output reg [15:0] laser_freq_thz_o,
   output reg [15:0] laser_freq_frac_o,
   output reg irq_o
);
   // ==========================================================
   // state machine codes
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SUM = 2'h1;
   localparam [1:0] ST_DIV1 = 2'h2;
   localparam [1:0] ST_DIV2 = 2'h3;

   // ==========================================================
   // storage
   reg software_output_enable_q;
   reg [15:0] grid_q;
   reg [15:0] fcf_thz_q;
   reg [15:0] fcf_frac_q;
   reg [15:0] nv_grid_q;
   reg [15:0] nv_thz_q;
   reg [15:0] nv_frac_q;
   reg [15:0] lf_thz_q;
   reg [15:0] lf_frac_q;
   reg [`IRQ_W-1:0] irq_stat_q;
   reg [`IRQ_W-1:0] irq_mask_q;
   reg [3:0] err_cond_q;
   reg [1:0] state_q;
   reg sum_load_q;
   reg div_start_q;
   reg [`FREQ_W-1:0] div_a_q;
   reg [`FREQ_W-1:0] div_b_q;

   wire [`FREQ_W-1:0] sum_w;
   wire sum_neg_w;
   wire div_busy_w;
   wire div_done_w;
   wire [`FREQ_W-1:0] quot_w;
   wire [`FREQ_W-1:0] rem_w;

   // ==========================================================
   // arithmetic helpers
   freq_sum u_sum (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .load_i(sum_load_q),
      .channel_i(channel_i),
      .grid_i(grid_q),
      .fcf_thz_i(fcf_thz_q),
      .fcf_frac_i(fcf_frac_q),
      .fine_tune_offset_i(fine_tune_offset_i),
      .sum_q(sum_w),
      .neg_q(sum_neg_w)
   );

   seq_div #(.W(`FREQ_W)) u_div (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .start_i(div_start_q),
      .dividend_i(div_a_q),
      .divisor_i(div_b_q),
      .busy_q(div_busy_w),
      .done_q(div_done_w),
      .quot_q(quot_w),
      .rem_q(rem_w)
   );

   // ==========================================================
   // access decode
   wire is_cfg;
   wire cfg_wr_ok;
   wire nv_restore;
   wire wr_known;
   wire rd_known;
   reg [15:0] rd_mux;

   assign is_cfg = (addr_i == `REG_GRID_SPACING) || (addr_i == `REG_FCF_THZ)
      || (addr_i == `REG_FCF_FRAC);
   // config is frozen while the output is lit
   assign cfg_wr_ok = wr_i && is_cfg && !software_output_enable_q;
   assign nv_restore = wr_i && (addr_i == `REG_NV_CTRL) && wdata_i[`NV_RESTORE_BIT]
      && !software_output_enable_q;
   assign wr_known = (addr_i == `REG_RESET_ENABLE) || is_cfg || (addr_i == `REG_IRQ_MASK)
      || (addr_i == `REG_NV_CTRL);
   assign rd_known = wr_known || (addr_i == `REG_IRQ_STATUS) || (addr_i == `REG_ERR_COND)
      || (addr_i == `REG_LASER_THZ) || (addr_i == `REG_LASER_FRAC);

   // read multiplexer, unused upper bits read zero
   always @* begin
      rd_mux = 16'h0000;
      case (addr_i)
         `REG_RESET_ENABLE: rd_mux[`ENA_BIT] = software_output_enable_q;
         `REG_GRID_SPACING: rd_mux = grid_q;
         `REG_FCF_THZ: rd_mux = fcf_thz_q;
         `REG_FCF_FRAC: rd_mux = fcf_frac_q;
         `REG_IRQ_STATUS: rd_mux[`IRQ_W-1:0] = irq_stat_q;
         `REG_IRQ_MASK: rd_mux[`IRQ_W-1:0] = irq_mask_q;
         `REG_ERR_COND: rd_mux[3:0] = err_cond_q;
         `REG_LASER_THZ: rd_mux = lf_thz_q;
         `REG_LASER_FRAC: rd_mux = lf_frac_q;
         default: rd_mux = 16'h0000;
      endcase
   end

   // ==========================================================
   // response: one cycle after the strobe, data zero on any refusal
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
         resp_valid_o <= 1'b0;
         resp_xe_o <= 1'b0;
         resp_cond_o <= `ERR_NONE;
         err_cond_q <= `ERR_NONE;
      end else begin
         resp_valid_o <= wr_i || rd_i;
         rdata_o <= 16'h0000;
         resp_xe_o <= 1'b0;
         resp_cond_o <= `ERR_NONE;
         if (wr_i) begin
            if (!wr_known) begin
               resp_xe_o <= 1'b1;
               resp_cond_o <= rd_known ? `ERR_NOT_WRITABLE : `ERR_BAD_REGISTER;
               err_cond_q <= rd_known ? `ERR_NOT_WRITABLE : `ERR_BAD_REGISTER;
            end else if ((is_cfg || (addr_i == `REG_NV_CTRL && wdata_i[`NV_RESTORE_BIT]))
                         && software_output_enable_q) begin
               resp_xe_o <= 1'b1;
               resp_cond_o <= `ERR_OUTPUT_ON;
               err_cond_q <= `ERR_OUTPUT_ON;
            end else begin
               rdata_o <= wdata_i;
               err_cond_q <= `ERR_NONE;
            end
         end else if (rd_i) begin
            if (rd_known) begin
               rdata_o <= rd_mux;
               err_cond_q <= `ERR_NONE;
            end else begin
               resp_xe_o <= 1'b1;
               resp_cond_o <= `ERR_BAD_REGISTER;
               err_cond_q <= `ERR_BAD_REGISTER;
            end
         end
      end
   end

   // ==========================================================
   // output enable bit, written only through the reset/enable word
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         software_output_enable_q <= 1'b0;
      end else if (wr_i && addr_i == `REG_RESET_ENABLE) begin
         software_output_enable_q <= wdata_i[`ENA_BIT];
      end
   end

   // ==========================================================
   // working configuration; each word stands alone so order is free
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         grid_q <= GRID_DEFAULT;
         fcf_thz_q <= FCF_THZ_DEFAULT;
         fcf_frac_q <= FCF_FRAC_DEFAULT;
      end else if (nv_restore) begin
         grid_q <= nv_grid_q;
         fcf_thz_q <= nv_thz_q;
         fcf_frac_q <= nv_frac_q;
      end else if (cfg_wr_ok) begin
         // full 16-bit value kept as sent, no limit applied; only the spacing is signed
         if (addr_i == `REG_GRID_SPACING)
            grid_q <= wdata_i;
         if (addr_i == `REG_FCF_THZ)
            fcf_thz_q <= wdata_i;
         if (addr_i == `REG_FCF_FRAC)
            fcf_frac_q <= wdata_i;
      end
   end

   // ==========================================================
   // saved defaults; a true part backs these with flash, here they
   // survive a restore but not a power-on reset
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nv_grid_q <= GRID_DEFAULT;
         nv_thz_q <= FCF_THZ_DEFAULT;
         nv_frac_q <= FCF_FRAC_DEFAULT;
      end else if (wr_i && addr_i == `REG_NV_CTRL && wdata_i[`NV_SAVE_BIT]
                   && !wdata_i[`NV_RESTORE_BIT]) begin
         nv_grid_q <= grid_q;
         nv_thz_q <= fcf_thz_q;
         nv_frac_q <= fcf_frac_q;
      end
   end

   // ==========================================================
   // tuning sequence: sum in MHz, divide by 100, then by 10000
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         sum_load_q <= 1'b0;
         div_start_q <= 1'b0;
         div_a_q <= {`FREQ_W{1'b0}};
         div_b_q <= {`FREQ_W{1'b0}};
         lf_thz_q <= FCF_THZ_DEFAULT;
         lf_frac_q <= FCF_FRAC_DEFAULT;
      end else begin
         sum_load_q <= 1'b0;
         div_start_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (tune_req_i) begin
                  sum_load_q <= 1'b1;
                  state_q <= ST_SUM;
               end
            end
            ST_SUM: begin
               // wait for the sum register, clamp below zero
               if (!sum_load_q) begin
                  div_a_q <= sum_neg_w ? {`FREQ_W{1'b0}} : sum_w;
                  div_b_q <= `MHZ_PER_DECI;
                  div_start_q <= 1'b1;
                  state_q <= ST_DIV1;
               end
            end
            ST_DIV1: begin
               if (div_done_w) begin
                  div_a_q <= quot_w;
                  div_b_q <= `DECI_PER_THZ;
                  div_start_q <= 1'b1;
                  state_q <= ST_DIV2;
               end
            end
            ST_DIV2: begin
               if (div_done_w) begin
                  // saturate an oversize THz figure rather than wrap
                  lf_thz_q <= (quot_w > `WORD_MAX) ? 16'hffff : quot_w[15:0];
                  lf_frac_q <= rem_w[15:0];
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   wire tune_done = (state_q == ST_DIV2) && div_done_w;
   wire tune_drop = tune_req_i && (state_q != ST_IDLE);
   wire reject_evt = (wr_i && (!wr_known || ((is_cfg
      || (addr_i == `REG_NV_CTRL && wdata_i[`NV_RESTORE_BIT])) && software_output_enable_q)))
      || (rd_i && !rd_known);

   // ==========================================================
   // sticky events, cleared by reading; a new event beats the clear
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_q <= {`IRQ_W{1'b0}};
         irq_mask_q <= {`IRQ_W{1'b0}};
      end else begin
         irq_stat_q <= ((rd_i && addr_i == `REG_IRQ_STATUS) ? {`IRQ_W{1'b0}} : irq_stat_q)
            | {tune_drop, tune_done, reject_evt};
         if (wr_i && addr_i == `REG_IRQ_MASK)
            irq_mask_q <= wdata_i[`IRQ_W-1:0];
      end
   end

   // ==========================================================
   // registered copies of state for the outside
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         tune_busy_o <= 1'b0;
         output_enable_o <= 1'b0;
         grid_spacing_o <= GRID_DEFAULT;
         first_channel_freq_thz_o <= FCF_THZ_DEFAULT;
         first_channel_freq_frac_o <= FCF_FRAC_DEFAULT;
         laser_freq_thz_o <= FCF_THZ_DEFAULT;
         laser_freq_frac_o <= FCF_FRAC_DEFAULT;
      end else begin
         irq_o <= |(irq_stat_q & irq_mask_q);
         tune_busy_o <= (state_q != ST_IDLE);
         output_enable_o <= software_output_enable_q;
         grid_spacing_o <= grid_q;
         first_channel_freq_thz_o <= fcf_thz_q;
         first_channel_freq_frac_o <= fcf_frac_q;
         laser_freq_thz_o <= lf_thz_q;
         laser_freq_frac_o <= lf_frac_q;
      end
   end
endmodule // chan_freq_regs

`default_nettype wire

/* test/chan_freq_regs_chk.sv */
// checker for the channel frequency register set, watching top-level ports
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module chan_freq_regs_chk (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic resp_valid_o,
   input wire logic resp_xe_o,
   input wire logic [3:0] resp_cond_o,
   input wire logic tune_busy_o,
   input wire logic output_enable_o,
   input wire logic [15:0] grid_spacing_o,
   input wire logic [15:0] laser_freq_thz_o
);
   logic [15:0] wd_q;
   wire cfg_w = (addr_i >= 8'h34) && (addr_i <= 8'h36);
   wire map_w = addr_i inside {8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3a, 8'h3b,
                               8'h40, 8'h41};
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ==========================================================
   // last written data, kept so lagging copies can be compared
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) wd_q <= 16'h0000;
      else if (wr_i) wd_q <= wdata_i;
   end

   // ==========================================================
   // response framing
   a_resp_follows: assert property ((wr_i || rd_i) |=> resp_valid_o)
      else $error("no response after strobe");
   a_resp_idle: assert property (!(wr_i || rd_i) |=> !resp_valid_o && !resp_xe_o
      && rdata_o == 16'h0000) else $error("response without strobe");
   // enable is required on both cycles so either lag reading of the copy holds
   a_refuse_on: assert property (wr_i && cfg_w && output_enable_o ##1 output_enable_o
      |-> resp_xe_o && resp_cond_o == 4'h3 && rdata_o == 16'h0000)
      else $error("config write not refused");
   a_write_echo: assert property (wr_i && cfg_w && !output_enable_o ##1 !output_enable_o
      |-> !resp_xe_o && rdata_o == $past(wdata_i)) else $error("write not echoed");
   a_grid_copy: assert property (wr_i && addr_i == 8'h34 && !output_enable_o
      ##1 (!output_enable_o && !wr_i) |=> grid_spacing_o == wd_q)
      else $error("grid value not stored");
   a_ro_refused: assert property (wr_i && (addr_i == 8'h40 || addr_i == 8'h41)
      |=> resp_xe_o && resp_cond_o == 4'h1) else $error("read-only word written");
   a_unmapped_err: assert property ((wr_i || rd_i) && !map_w
      |=> resp_xe_o && resp_cond_o == 4'h2) else $error("unmapped access accepted");
   a_enable_bit: assert property (wr_i && addr_i == 8'h32 ##1 !wr_i
      |=> output_enable_o == wd_q[3]) else $error("enable bit not followed");
   a_laser_hold: assert property ($changed(laser_freq_thz_o)
      |-> $past(tune_busy_o) || $past(tune_busy_o, 2)) else $error("laser word moved idle");
   a_tune_ends: assert property ($rose(tune_busy_o) |-> ##[1:200] !tune_busy_o)
      else $error("tuning never ends");
endmodule // chan_freq_regs_chk

bind chan_freq_regs chan_freq_regs_chk chk (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .resp_valid_o, .resp_xe_o, .resp_cond_o, .tune_busy_o, .output_enable_o,
   .grid_spacing_o, .laser_freq_thz_o);

`default_nettype wire

/* test/tune_engine.sv */
// tuning engine model: requests one frequency computation per start pulse
// assumes the block's clock and reset; a start pulse while the block is busy is dropped
`timescale 1ns/1ns
`default_nettype none

module tune_engine (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic busy_i,
   input wire logic start_i,
   input wire logic [15:0] ch_i,
   input wire logic [15:0] ftf_i,
   output logic tune_req_o,
   output logic [15:0] channel_o,
   output logic [15:0] fine_tune_offset_o
);
   logic [1:0] hold_q;

   // ==========================================================
   // one-cycle request; operands held two cycles past it, then scrambled
   // so a late sample in the block shows up as a wrong frequency
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tune_req_o <= 1'b0;
         hold_q <= 2'd0;
         channel_o <= 16'h0000;
         fine_tune_offset_o <= 16'h0000;
      end else begin
         tune_req_o <= 1'b0;
         if (start_i && !busy_i && hold_q == 2'd0) begin
            tune_req_o <= 1'b1;
            channel_o <= ch_i;
            fine_tune_offset_o <= ftf_i;
            hold_q <= 2'd2;
         end else if (hold_q != 2'd0) begin
            hold_q <= hold_q - 2'd1;
         end else begin
            channel_o <= ~channel_o;
            fine_tune_offset_o <= ~fine_tune_offset_o;
         end
      end
   end
endmodule // tune_engine

`default_nettype wire

/* test/chan_freq_regs_tb.sv */
// self-checking bench for the channel frequency register set
// assumes the checker is bound in and the tuning engine model drives tuning
`timescale 1ns/1ns
`default_nettype none

module chan_freq_regs_tb;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic start = 1'b0;
   logic [15:0] ch = 16'h0003;
   logic [15:0] fine_tune_offset = 16'h00fa;
   wire tune_req_i, resp_valid_o, resp_xe_o, tune_busy_o, output_enable_o, irq_o;
   wire [15:0] channel_i, fine_tune_offset_i, rdata_o, laser_freq_thz_o, laser_freq_frac_o;
   wire [15:0] grid_spacing_o, first_channel_freq_thz_o, first_channel_freq_frac_o;
   wire [3:0] resp_cond_o;
   int fail_count = 0;
   int checks = 0;
   longint tot;

   always #25 mclk_i = ~mclk_i;

   chan_freq_regs #(.GRID_DEFAULT(16'h01f4), .FCF_THZ_DEFAULT(16'h00c2),
      .FCF_FRAC_DEFAULT(16'h06d6)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .resp_valid_o(resp_valid_o), .resp_xe_o(resp_xe_o), .resp_cond_o(resp_cond_o),
      .tune_req_i(tune_req_i), .channel_i(channel_i), .fine_tune_offset_i(fine_tune_offset_i),
      .tune_busy_o(tune_busy_o), .output_enable_o(output_enable_o),
      .grid_spacing_o(grid_spacing_o), .first_channel_freq_thz_o(first_channel_freq_thz_o),
      .first_channel_freq_frac_o(first_channel_freq_frac_o),
      .laser_freq_thz_o(laser_freq_thz_o), .laser_freq_frac_o(laser_freq_frac_o),
      .irq_o(irq_o));

   tune_engine eng (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .busy_i(tune_busy_o),
      .start_i(start), .ch_i(ch), .ftf_i(fine_tune_offset), .tune_req_o(tune_req_i),
      .channel_o(channel_i), .fine_tune_offset_o(fine_tune_offset_i));

   // ==========================================================
   // shared helpers
   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one strobe cycle, response sampled just after the answering edge
   task automatic xp(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] ed, input logic xe, input logic [3:0] cond);
      @(posedge mclk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, ed, "data");
      chk({10'h000, resp_valid_o, resp_xe_o, resp_cond_o}, {10'h000, 1'b1, xe, cond}, "resp");
   endtask

   task automatic wait_busy(input logic lvl, input int bound);
      int n;
      n = 0;
      while (tune_busy_o !== lvl && n < bound) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      if (n >= bound) begin
         fail_count++;
         $display("ERROR %0t tuning wait ran out", $time);
         final_report();
      end
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge mclk_i);
      #1;
      chk({15'h0000, irq_o}, {15'h0000, exp}, "irq");
   endtask

   // ==========================================================
   // scenarios
   task automatic t_defaults;
      xp(1'b0, 8'h34, 16'h0000, 16'h01f4, 1'b0, 4'h0);
      xp(1'b0, 8'h35, 16'h0000, 16'h00c2, 1'b0, 4'h0);
      xp(1'b0, 8'h36, 16'h0000, 16'h06d6, 1'b0, 4'h0);
      xp(1'b0, 8'h40, 16'h0000, 16'h00c2, 1'b0, 4'h0);
      xp(1'b0, 8'h41, 16'h0000, 16'h06d6, 1'b0, 4'h0);
   endtask

   // extremes of the signed range, then the spacing used for tuning
   task automatic t_config;
      logic [15:0] v [3] = '{16'h8000, 16'h7fff, 16'h0032};
      foreach (v[i]) begin
         xp(1'b1, 8'h34, v[i], v[i], 1'b0, 4'h0);
         xp(1'b0, 8'h34, 16'h0000, v[i], 1'b0, 4'h0);
      end
      xp(1'b1, 8'h36, 16'h03e8, 16'h03e8, 1'b0, 4'h0);
      xp(1'b1, 8'h35, 16'h00c1, 16'h00c1, 1'b0, 4'h0);
      xp(1'b0, 8'h36, 16'h0000, 16'h03e8, 1'b0, 4'h0);
      xp(1'b0, 8'h40, 16'h0000, 16'h00c2, 1'b0, 4'h0);
      chk(first_channel_freq_thz_o, 16'h00c1, "fcf thz port");
      chk(first_channel_freq_frac_o, 16'h03e8, "fcf frac port");
      chk(grid_spacing_o, 16'h0032, "grid port");
   endtask

   task automatic t_tune;
      tot = longint'(ch - 1) * 50 * 100 + 193 * 1000000 + 1000 * 100 + longint'(fine_tune_offset);
      @(posedge mclk_i);
      start <= 1'b1;
      @(posedge mclk_i);
      start <= 1'b0;
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 200);
      chk(laser_freq_thz_o, 16'(tot / 1000000), "laser thz port");
      chk(laser_freq_frac_o, 16'((tot / 100) % 10000), "laser frac port");
      xp(1'b0, 8'h40, 16'h0000, 16'(tot / 1000000), 1'b0, 4'h0);
      xp(1'b0, 8'h41, 16'h0000, 16'((tot / 100) % 10000), 1'b0, 4'h0);
      xp(1'b0, 8'h38, 16'h0000, 16'h0002, 1'b0, 4'h0);
   endtask

   // host has both first-channel words set before enabling
   task automatic t_enabled;
      xp(1'b1, 8'h39, 16'h0001, 16'h0001, 1'b0, 4'h0);
      xp(1'b1, 8'h32, 16'h0008, 16'h0008, 1'b0, 4'h0);
      irq_is(1'b0);
      chk({15'h0000, output_enable_o}, 16'h0001, "enable");
      for (int a = 8'h34; a <= 8'h36; a++) begin
         xp(1'b1, 8'(a), 16'h1234, 16'h0000, 1'b1, 4'h3);
      end
      irq_is(1'b1);
      xp(1'b0, 8'h34, 16'h0000, 16'h0032, 1'b0, 4'h0);
      xp(1'b0, 8'h38, 16'h0000, 16'h0001, 1'b0, 4'h0);
      irq_is(1'b0);
      xp(1'b1, 8'h39, 16'h0000, 16'h0000, 1'b0, 4'h0);
      xp(1'b1, 8'h35, 16'h0001, 16'h0000, 1'b1, 4'h3);
      irq_is(1'b0);
      xp(1'b0, 8'h35, 16'h0000, 16'h00c1, 1'b0, 4'h0);
      xp(1'b1, 8'h32, 16'h0000, 16'h0000, 1'b0, 4'h0);
      xp(1'b1, 8'h34, 16'h0064, 16'h0064, 1'b0, 4'h0);
      chk({15'h0000, output_enable_o}, 16'h0000, "disable");
   endtask

   task automatic t_bad_access;
      xp(1'b0, 8'h7f, 16'h0000, 16'h0000, 1'b1, 4'h2);
      xp(1'b1, 8'h40, 16'h5555, 16'h0000, 1'b1, 4'h1);
      xp(1'b1, 8'h41, 16'h5555, 16'h0000, 1'b1, 4'h1);
      xp(1'b0, 8'h40, 16'h0000, 16'(tot / 1000000), 1'b0, 4'h0);
      // save the working spacing, overwrite it, then bring the saved one back
      xp(1'b1, 8'h3b, 16'h0001, 16'h0001, 1'b0, 4'h0);
      xp(1'b1, 8'h34, 16'h0010, 16'h0010, 1'b0, 4'h0);
      xp(1'b1, 8'h3b, 16'h0002, 16'h0002, 1'b0, 4'h0);
      xp(1'b0, 8'h34, 16'h0000, 16'h0064, 1'b0, 4'h0);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_defaults();
      t_config();
      t_tune();
      t_enabled();
      t_bad_access();
      final_report();
   end
endmodule // chan_freq_regs_tb

`default_nettype wire
